// ==== src/tpm_timer.sv ====
// One-pulse timer core: free-running 16-bit counter, trigger capture, two compares and a pulse pin.
// Assumes a plain register port (one-cycle strobes, read data the next cycle) and inputs
// that are already synchronous to ref_clk_in.
// Function
// - One-pulse operation runs only while software sets the one-pulse select bit.
// - One-pulse uses capture channel one to trigger and compare one to end.
// - Trigger is the rising or falling trigger pin edge per edge select bit.
// - Pulse pin is driven by the timer only while compare-one output enable is set.
// - Each valid trigger reloads the counter with FFFC.
// - Each valid trigger drives the pulse pin to the during-pulse level.
// - Each valid trigger sets the capture flag and loads capture one with FFFD.
// - Capture flag raises the interrupt when capture interrupt enable is set.
// - Capture flag clears after a status read seeing it, then a capture-low access.
// - Counter matching compare one drives the pin to the after-pulse level.
// - Counter advances at CPU clock divided by 2, 4 or 8 per clock select.
// - With external clock selected the counter advances once per external period.
// - One-pulse never sets compare flag one; compare flag two still works.
// - With one-pulse and PWM both selected, one-pulse is inactive.
// - Divide-by-two compares act at equality; other clocks one count later.
// - Compare two and its flag stay usable; during level serves only the pulse.
`timescale 1ns/1ps

module tpm_timer
   import tpm_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Register port
   input wire logic [3:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   // Pins
   input wire logic trigger_input_pin_in,
   input wire logic ext_timer_clk_in,
   output logic pulse_output_pin_out,
   output logic pulse_output_oe_out,
   // Interrupt
   output logic irq_out
);

   tpm_state_t s;
   tpm_state_t next_s;
   tpm_tick_if tk ();

   logic one_pulse_on;
   logic pwm_on;
   logic is_div2;
   logic rise;
   logic fall;
   logic trig_edge;
   logic trigger;
   logic tick;
   logic [15:0] cnt_inc;
   logic cmp1_hit;
   logic cmp2_hit;
   logic cap1_lo_access;
   logic cmp1_lo_access;
   logic cmp2_lo_access;
   logic status_read;
   logic ev_read;
   logic [7:0] rd_val;

   // Rate choice goes to the prescaler straight from control_reg_two
   assign tk.clk_sel = tpm_clk_sel_t'(s.ctrl2[`TPM_CR2_CLK_HI:`TPM_CR2_CLK_LO]);
   assign tk.ext_clk = ext_timer_clk_in;
   assign tick = tk.tick;

   tpm_prescaler tpm_prescaler_inst (
      .ref_clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .tk(tk.gen)
   );

   // Mode decode; PWM wins so one-pulse is shut off when both are set
   assign pwm_on = s.ctrl2[`TPM_CR2_PWM];
   assign one_pulse_on = s.ctrl2[`TPM_CR2_ONE_PULSE] & ~pwm_on;
   assign is_div2 = (tk.clk_sel == TPM_DIV2);

   // Trigger edge detect on the capture-one pin. The previous level resets low, so a pin
   // idling high shows one rising edge after reset; harmless while one-pulse select is clear.
   assign rise = trigger_input_pin_in & ~s.trig_prev;
   assign fall = ~trigger_input_pin_in & s.trig_prev;
   assign trig_edge = s.ctrl1[`TPM_CR1_EDGE] ? rise : fall;
   assign trigger = one_pulse_on & trig_edge;

   // Compare match: at equality for divide-by-two, one count later otherwise
   // Divide-by-two looks at the incremented count, so both variants act on a tick edge
   assign cnt_inc = s.counter + 16'h0001;
   assign cmp1_hit = tick & (is_div2 ? (cnt_inc == s.cmp1) : (s.counter == s.cmp1));
   assign cmp2_hit = tick & (is_div2 ? (cnt_inc == s.cmp2) : (s.counter == s.cmp2));

   // Bus side effects
   assign status_read = reg_rd_in & (reg_addr_in == `TPM_ADDR_STATUS);
   assign ev_read = reg_rd_in & (reg_addr_in == `TPM_ADDR_IRQ_STAT);
   assign cap1_lo_access = (reg_rd_in | reg_wr_in) & (reg_addr_in == `TPM_ADDR_CAP1_LO);
   assign cmp1_lo_access = (reg_rd_in | reg_wr_in) & (reg_addr_in == `TPM_ADDR_CMP1_LO);
   assign cmp2_lo_access = (reg_rd_in | reg_wr_in) & (reg_addr_in == `TPM_ADDR_CMP2_LO);

   // Read mux; unmapped addresses read as zero
   always_comb begin
      rd_val = `TPM_RDATA_IDLE;
      case (reg_addr_in)
         `TPM_ADDR_CTRL1: rd_val = s.ctrl1;
         `TPM_ADDR_CTRL2: rd_val = s.ctrl2;
         `TPM_ADDR_STATUS: begin
            rd_val[`TPM_SR_CAP1] = s.cap1_flag;
            rd_val[`TPM_SR_CMP1] = s.cmp1_flag;
            rd_val[`TPM_SR_CMP2] = s.cmp2_flag;
         end
         `TPM_ADDR_CAP1_HI: rd_val = s.cap1[15:8];
         `TPM_ADDR_CAP1_LO: rd_val = s.cap1[7:0];
         `TPM_ADDR_CMP1_HI: rd_val = s.cmp1[15:8];
         `TPM_ADDR_CMP1_LO: rd_val = s.cmp1[7:0];
         `TPM_ADDR_CMP2_HI: rd_val = s.cmp2[15:8];
         `TPM_ADDR_CMP2_LO: rd_val = s.cmp2[7:0];
         `TPM_ADDR_CNT_HI: rd_val = s.counter[15:8];
         `TPM_ADDR_CNT_LO: rd_val = s.counter[7:0];
         `TPM_ADDR_IRQ_STAT: rd_val = {5'h00, s.ev_stat};
         `TPM_ADDR_IRQ_MASK: rd_val = {5'h00, s.ev_mask};
         default: rd_val = `TPM_RDATA_IDLE;
      endcase
   end

   // Next-state logic; clears are applied before sets so a same-cycle event wins
   always_comb begin
      next_s = s;
      next_s.trig_prev = trigger_input_pin_in;
      next_s.rdata = reg_rd_in ? rd_val : `TPM_RDATA_IDLE;

      // Register writes
      if (reg_wr_in) begin
         case (reg_addr_in)
            `TPM_ADDR_CTRL1: next_s.ctrl1 = reg_wdata_in;
            `TPM_ADDR_CTRL2: next_s.ctrl2 = reg_wdata_in;
            `TPM_ADDR_CMP1_HI: next_s.cmp1[15:8] = reg_wdata_in;
            `TPM_ADDR_CMP1_LO: next_s.cmp1[7:0] = reg_wdata_in;
            `TPM_ADDR_CMP2_HI: next_s.cmp2[15:8] = reg_wdata_in;
            `TPM_ADDR_CMP2_LO: next_s.cmp2[7:0] = reg_wdata_in;
            `TPM_ADDR_IRQ_MASK: next_s.ev_mask = reg_wdata_in[2:0];
            default: next_s.ev_mask = s.ev_mask;
         endcase
      end

      // First clear step: status read arms each flag it saw set
      if (status_read) begin
         next_s.cap1_armed = s.cap1_flag | s.cap1_armed;
         next_s.cmp1_armed = s.cmp1_flag | s.cmp1_armed;
         next_s.cmp2_armed = s.cmp2_flag | s.cmp2_armed;
      end
      // Second clear step: low-byte access clears an armed flag
      if (cap1_lo_access && s.cap1_armed) begin
         next_s.cap1_flag = 1'b0;
         next_s.cap1_armed = 1'b0;
      end
      if (cmp1_lo_access && s.cmp1_armed) begin
         next_s.cmp1_flag = 1'b0;
         next_s.cmp1_armed = 1'b0;
      end
      if (cmp2_lo_access && s.cmp2_armed) begin
         next_s.cmp2_flag = 1'b0;
         next_s.cmp2_armed = 1'b0;
      end
      if (ev_read) begin
         next_s.ev_stat = `TPM_EV_RST;
      end

      // Free-running counter, wraps from FFFF to 0000
      if (tick) begin
         next_s.counter = cnt_inc;
      end

      // Compare one ends the pulse; its flag only outside one-pulse and PWM
      if (cmp1_hit) begin
         next_s.pin = s.ctrl1[`TPM_CR1_LVL_AFTER];
         if (!one_pulse_on && !pwm_on) begin
            next_s.cmp1_flag = 1'b1;
         end
         if (one_pulse_on) begin
            next_s.ev_stat[`TPM_EV_END] = 1'b1;
         end
      end

      // Compare two only flags elapsed time; it never touches the pin
      if (cmp2_hit && !pwm_on) begin
         next_s.cmp2_flag = 1'b1;
         next_s.ev_stat[`TPM_EV_CMP2] = 1'b1;
      end

      // Valid trigger overrides everything else on the counter and pin
      if (trigger) begin
         next_s.counter = `TPM_CNT_PRESET;
         next_s.pin = s.ctrl1[`TPM_CR1_LVL_DURING];
         next_s.cap1 = `TPM_CAP_PRESET;
         next_s.cap1_flag = 1'b1;
         next_s.ev_stat[`TPM_EV_TRIG] = 1'b1;
      end

      // Pin handed to the timer only with the output enable bit
      next_s.pin_oe = next_s.ctrl2[`TPM_CR2_OUT_EN];

      // One level interrupt: masked event bits plus the flag enables
      next_s.irq = (|(next_s.ev_stat & next_s.ev_mask))
         | (next_s.cap1_flag & next_s.ctrl1[`TPM_CR1_CAP_IE])
         | ((next_s.cmp1_flag | next_s.cmp2_flag) & next_s.ctrl1[`TPM_CR1_CMP_IE]);
   end

   // State register; pin latch starts low
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s.ctrl1 <= `TPM_CTRL_RST;
         s.ctrl2 <= `TPM_CTRL_RST;
         s.counter <= `TPM_CNT_RST;
         s.cap1 <= `TPM_CAP_RST;
         s.cmp1 <= `TPM_CMP_RST;
         s.cmp2 <= `TPM_CMP_RST;
         s.cap1_flag <= 1'b0;
         s.cmp1_flag <= 1'b0;
         s.cmp2_flag <= 1'b0;
         s.cap1_armed <= 1'b0;
         s.cmp1_armed <= 1'b0;
         s.cmp2_armed <= 1'b0;
         s.trig_prev <= 1'b0;
         s.pin <= 1'b0;
         s.pin_oe <= 1'b0;
         s.ev_stat <= `TPM_EV_RST;
         s.ev_mask <= `TPM_EV_RST;
         s.rdata <= `TPM_RDATA_IDLE;
         s.irq <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   // Outputs straight from the state register
   assign reg_rdata_out = s.rdata;
   assign pulse_output_pin_out = s.pin;
   assign pulse_output_oe_out = s.pin_oe;
   assign irq_out = s.irq;

   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_trigger_reload: assert property (trigger |=> (s.counter == `TPM_CNT_PRESET))
      else $error("counter not reloaded on trigger");
   a_trigger_level: assert property (trigger |=>
      (pulse_output_pin_out == $past(s.ctrl1[`TPM_CR1_LVL_DURING])))
      else $error("pin not at during-pulse level after trigger");
   a_trigger_capture: assert property (trigger |=> (s.cap1_flag && s.cap1 == `TPM_CAP_PRESET))
      else $error("capture flag or value wrong after trigger");
   a_capture_irq: assert property ((s.cap1_flag && s.ctrl1[`TPM_CR1_CAP_IE]) |-> irq_out)
      else $error("capture flag did not raise the interrupt");
   a_flag_clear_seq: assert property ($fell(s.cap1_flag) |-> $past(s.cap1_armed && cap1_lo_access))
      else $error("capture flag cleared without the two-step sequence");
   a_flag_set_mode: assert property ($rose(s.cap1_flag) |-> $past(one_pulse_on && trig_edge))
      else $error("capture flag set outside one-pulse operation");
   a_pulse_end: assert property ((cmp1_hit && !trigger) |=>
      (pulse_output_pin_out == $past(s.ctrl1[`TPM_CR1_LVL_AFTER])))
      else $error("pin not at after-pulse level on compare one");
   a_no_cmp1_flag: assert property ($rose(s.cmp1_flag) |-> !$past(one_pulse_on))
      else $error("compare flag one set in one-pulse operation");
   a_cmp2_flag: assert property ((cmp2_hit && !pwm_on) |=> s.cmp2_flag)
      else $error("compare two did not set its flag");
   a_count_step: assert property ((tick && !trigger) |=> (s.counter == $past(cnt_inc)))
      else $error("counter did not advance on tick");
   a_oe_enable: assert property ($rose(pulse_output_oe_out) |->
      $past(reg_wr_in && reg_addr_in == `TPM_ADDR_CTRL2 && reg_wdata_in[`TPM_CR2_OUT_EN]))
      else $error("output enable rose without a control write");

   // Supporting checks for paths the bench reaches only indirectly

   // Enable is a registered copy of its control bit
   a_oe_tracks: assert property (pulse_output_oe_out == s.ctrl2[`TPM_CR2_OUT_EN])
      else $error("output enable differs from its control bit");

   // Pin moves only on a trigger or a compare-one match; compare two leaves it alone
   a_pin_hold: assert property ((!trigger && !cmp1_hit) |=> $stable(pulse_output_pin_out))
      else $error("pulse pin moved without a trigger or a match");

   // Counter frozen between ticks; a stray step would shorten the pulse
   a_count_hold: assert property ((!tick && !trigger) |=> $stable(s.counter))
      else $error("counter moved between ticks");

   // Wrap from the top value to zero, so pulses started at the preset still end
   a_count_wrap: assert property ((tick && !trigger && s.counter == '1) |=> (s.counter == '0))
      else $error("counter did not wrap to zero");

   // Capture register loads only on a trigger
   a_cap_hold: assert property (!trigger |=> $stable(s.cap1))
      else $error("capture register changed without a trigger");

   // Compare one changes only by a bus write; the timer never loads it
   a_cmp_hold: assert property (!reg_wr_in |=> $stable(s.cmp1))
      else $error("compare one changed without a write");

   // Trigger is also recorded in the event layer
   a_trigger_event: assert property (trigger |=> s.ev_stat[`TPM_EV_TRIG])
      else $error("trigger event not recorded");

   // Enabled capture interrupt follows the trigger unless software rewrites control one
   a_trigger_irq: assert property ((trigger && s.ctrl1[`TPM_CR1_CAP_IE] && !reg_wr_in) |=> irq_out)
      else $error("trigger did not raise the capture interrupt");

   // First clear step: a status read that sees the flag set arms the clear
   a_clear_arm: assert property ((status_read && s.cap1_flag) |=> s.cap1_armed)
      else $error("status read did not arm the capture clear");

   // Without the status read first, a low-byte access must not clear the flag
   a_clear_guard: assert property ((s.cap1_flag && !s.cap1_armed) |=> s.cap1_flag)
      else $error("capture flag cleared without a status read");

   // Edges outside one-pulse, or with PWM also set, leave the capture side alone
   a_mode_gate: assert property ((trig_edge && !one_pulse_on) |=> !$rose(s.cap1_flag))
      else $error("capture flag rose outside one-pulse operation");

   // With PWM selected neither compare flag may rise
   a_pwm_flags: assert property (pwm_on |=> (!$rose(s.cmp2_flag) && !$rose(s.cmp1_flag)))
      else $error("compare flag rose with PWM selected");

   // Pulse end goes to the event layer, since compare flag one stays clear
   a_end_event: assert property ((cmp1_hit && one_pulse_on) |=> s.ev_stat[`TPM_EV_END])
      else $error("pulse end event not recorded");

   // Event read clears the layer when nothing new arrives in the same cycle
   a_ev_clear: assert property ((ev_read && !trigger && !cmp1_hit && !cmp2_hit) |=> (s.ev_stat == `TPM_EV_RST))
      else $error("event status not cleared by its read");

   // Read data idle outside the cycle after a read, so stale bytes never leak
   a_rdata_idle: assert property (!reg_rd_in |=> (reg_rdata_out == `TPM_RDATA_IDLE))
      else $error("read data not idle outside a read");

   // Main scenarios: trigger, pulse end, two-step clear, interrupt, external tick
   c_trigger: cover property (trigger);
   c_ext_tick: cover property (tick && tk.clk_sel == TPM_EXT);
   c_pulse_end: cover property (trigger ##[1:1000] (cmp1_hit && one_pulse_on));
   c_flag_clear: cover property (status_read && s.cap1_flag ##[1:20] $fell(s.cap1_flag));
   c_irq: cover property ($rose(irq_out));

endmodule

// ==== src/tpm_defs.svh ====
// Register map, bit positions, reset values and fixed counts of the one-pulse timer.
// Assumes inclusion by bare name from the package; the design modules use its macros without including it.
`ifndef TPM_DEFS_SVH
`define TPM_DEFS_SVH

// Register addresses (byte registers on a 4-bit address)
`define TPM_ADDR_CTRL1 4'h0
`define TPM_ADDR_CTRL2 4'h1
`define TPM_ADDR_STATUS 4'h2
`define TPM_ADDR_CAP1_HI 4'h3
`define TPM_ADDR_CAP1_LO 4'h4
`define TPM_ADDR_CMP1_HI 4'h5
`define TPM_ADDR_CMP1_LO 4'h6
`define TPM_ADDR_CMP2_HI 4'h7
`define TPM_ADDR_CMP2_LO 4'h8
`define TPM_ADDR_CNT_HI 4'h9
`define TPM_ADDR_CNT_LO 4'hA
`define TPM_ADDR_IRQ_STAT 4'hB
`define TPM_ADDR_IRQ_MASK 4'hC

// control_reg_one fields
`define TPM_CR1_CAP_IE 7
`define TPM_CR1_CMP_IE 6
`define TPM_CR1_LVL_DURING 2
`define TPM_CR1_EDGE 1
`define TPM_CR1_LVL_AFTER 0

// control_reg_two fields
`define TPM_CR2_OUT_EN 7
`define TPM_CR2_ONE_PULSE 5
`define TPM_CR2_PWM 4
`define TPM_CR2_CLK_HI 3
`define TPM_CR2_CLK_LO 2

// timer_status_reg fields
`define TPM_SR_CAP1 7
`define TPM_SR_CMP1 6
`define TPM_SR_CMP2 3

// Event status and mask fields
`define TPM_EV_TRIG 0
`define TPM_EV_END 1
`define TPM_EV_CMP2 2

// Reset and preset values
`define TPM_CTRL_RST 8'h00
`define TPM_CNT_RST 16'hFFFC
`define TPM_CNT_PRESET 16'hFFFC
`define TPM_CAP_PRESET 16'hFFFD
`define TPM_CAP_RST 16'h0000
`define TPM_CMP_RST 16'h8000
`define TPM_EV_RST 3'h0
`define TPM_RDATA_IDLE 8'h00

// Prescaler masks: tick when the low counter bits are all ones
`define TPM_PRE_MASK_DIV2 3'h1
`define TPM_PRE_MASK_DIV4 3'h3
`define TPM_PRE_MASK_DIV8 3'h7
`define TPM_PRE_RST 3'h0
`define TPM_PRE_STEP 3'h1

`endif

// ==== src/tpm_pkg.sv ====
// Types shared by the one-pulse timer and its prescaler.
// Assumes tpm_defs.svh is on the include path.
`include "tpm_defs.svh"

package tpm_pkg;

   // Timer clock choice, as held in control_reg_two
   typedef enum logic [1:0] {
      TPM_DIV4 = 2'b00,
      TPM_DIV2 = 2'b01,
      TPM_DIV8 = 2'b10,
      TPM_EXT  = 2'b11
   } tpm_clk_sel_t;

   // Whole state of the timer core
   typedef struct packed {
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [15:0] counter;
      logic [15:0] cap1;
      logic [15:0] cmp1;
      logic [15:0] cmp2;
      logic cap1_flag;
      logic cmp1_flag;
      logic cmp2_flag;
      logic cap1_armed;
      logic cmp1_armed;
      logic cmp2_armed;
      logic trig_prev;
      logic pin;
      logic pin_oe;
      logic [2:0] ev_stat;
      logic [2:0] ev_mask;
      logic [7:0] rdata;
      logic irq;
   } tpm_state_t;

   // Whole state of the prescaler
   typedef struct packed {
      logic [2:0] cnt;
      logic ext_prev;
      logic tick;
   } tpm_pre_state_t;

endpackage

// ==== src/tpm_tick_if.sv ====
// Carrier between the timer core and its prescaler.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps

interface tpm_tick_if;
   import tpm_pkg::*;
   tpm_clk_sel_t clk_sel;
   logic ext_clk;
   logic tick;

   // Core chooses the rate and forwards the external clock level
   modport core (output clk_sel, output ext_clk, input tick);
   // Prescaler turns the choice into a one-cycle tick
   modport gen (input clk_sel, input ext_clk, output tick);
endinterface

// ==== src/tpm_prescaler.sv ====
// Timer clock enable: CPU clock divided by 2, 4 or 8, or one tick per external clock period.
// Assumes the external clock level is synchronous to ref_clk_in and slower than half its rate.
`timescale 1ns/1ps

module tpm_prescaler
   import tpm_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Rate choice and tick
   tpm_tick_if.gen tk
);

   tpm_pre_state_t s;
   tpm_pre_state_t next_s;
   logic [2:0] mask;

   // Divider and external edge detect; tick is registered so it is one clean cycle
   always_comb begin
      next_s = s;
      next_s.cnt = s.cnt + `TPM_PRE_STEP;
      next_s.ext_prev = tk.ext_clk;
      mask = `TPM_PRE_MASK_DIV4;
      case (tk.clk_sel)
         TPM_DIV2: mask = `TPM_PRE_MASK_DIV2;
         TPM_DIV4: mask = `TPM_PRE_MASK_DIV4;
         TPM_DIV8: mask = `TPM_PRE_MASK_DIV8;
         default: mask = `TPM_PRE_MASK_DIV8;
      endcase
      if (tk.clk_sel == TPM_EXT) begin
         next_s.tick = tk.ext_clk & ~s.ext_prev;
      end else begin
         next_s.tick = ((s.cnt & mask) == mask);
      end
   end

   // State register
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s.cnt <= `TPM_PRE_RST;
         s.ext_prev <= 1'b0;
         s.tick <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   assign tk.tick = s.tick;

   default clocking pre_cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_ext_tick_edge: assert property ((tk.clk_sel == TPM_EXT && $past(tk.clk_sel) == TPM_EXT && tk.tick) |->
      ($past(tk.ext_clk) && !$past(tk.ext_clk, 2)))
      else $error("external tick without an external clock rise");
   a_div2_rate: assert property ((tk.clk_sel == TPM_DIV2 && $past(tk.clk_sel) == TPM_DIV2 && tk.tick) |=>
      (!tk.tick ##1 (tk.clk_sel != TPM_DIV2 || tk.tick)))
      else $error("divide by two tick spacing wrong");
   a_div8_gap: assert property ((tk.tick && tk.clk_sel == TPM_DIV8) ##1 (tk.clk_sel == TPM_DIV8)[*7] |->
      !$past(tk.tick, 1) && !$past(tk.tick, 6))
      else $error("divide by eight tick too early");

endmodule

// ==== bench/tpm_far_side.sv ====
// Far side of the pulse timer: trigger source, external timer clock and pulse load.
// Assumes the bench asks for trigger levels and owns the single reference clock.
`timescale 1ns/1ps

module tpm_far_side (
   // Clock and requests
   input wire logic ref_clk_in,
   input wire logic want_level_in,
   input wire logic ext_run_in,
   // Pins
   output logic trigger_out,
   output logic ext_clk_out,
   input wire logic pin_in,
   input wire logic pin_oe_in,
   output logic load_level_out
);
   logic [1:0] div_cnt;

   // Known levels from time zero
   initial begin
      trigger_out = 1'b0;
      ext_clk_out = 1'b0;
      div_cnt = 2'h0;
   end

   // Trigger pin is driven at all times, so a floating input needs no pull
   always @(posedge ref_clk_in) begin
      trigger_out <= want_level_in;
   end

   // External clock stands low when unused; half period of 3 keeps it below ref/2
   always @(posedge ref_clk_in) begin
      if (!ext_run_in) begin
         ext_clk_out <= 1'b0;
         div_cnt <= 2'h0;
      end else if (div_cnt == 2'h2) begin
         ext_clk_out <= ~ext_clk_out;
         div_cnt <= 2'h0;
      end else begin
         div_cnt <= div_cnt + 2'h1;
      end
   end

   // Load has a pull-up, so an undriven pin reads high
   assign load_level_out = pin_oe_in ? pin_in : 1'b1;
endmodule

// ==== bench/test_timer_one_pulse_mode.sv ====
// Self-checking bench for the one-pulse timer.
// Assumes tpm_pkg, tpm_tick_if, the design modules and tpm_far_side are compiled first.
`timescale 1ns/1ps

module test_timer_one_pulse_mode;
   logic ref_clk_in = 1'b0;
   logic rst_n_in = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic want = 1'b0;
   logic ext_run = 1'b0;
   logic [7:0] reg_rdata_out;
   logic trig, ext_clk, pin, pin_oe, irq, load;
   logic rd_seen = 1'b0;
   logic pin_last = 1'b0;
   logic after_lvl = 1'b0;
   logic [7:0] rd_q[$];
   logic pin_q[$];
   int fail_count = 0;
   int n_tests = 0;
   int seed = 19;
   int lo_cyc, hi_cyc, ticks;
   time t_start = 0;
   logic [15:0] v;
   logic [3:0] rst_addr [12] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hB, 4'hC, 4'hD};
   logic [7:0] rst_val [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [1:0] sel [4] = '{2'b01, 2'b00, 2'b10, 2'b11};
   int dv [4] = '{2, 4, 8, 6};

   always #5 ref_clk_in = ~ref_clk_in;

   tpm_timer tpm_timer_inst (
      .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
      .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
      .reg_rdata_out(reg_rdata_out), .trigger_input_pin_in(trig), .ext_timer_clk_in(ext_clk),
      .pulse_output_pin_out(pin), .pulse_output_oe_out(pin_oe), .irq_out(irq));

   tpm_far_side tpm_far_side_inst (
      .ref_clk_in(ref_clk_in), .want_level_in(want), .ext_run_in(ext_run), .trigger_out(trig),
      .ext_clk_out(ext_clk), .pin_in(pin), .pin_oe_in(pin_oe), .load_level_out(load));

   // Byte comparison, counted
   task automatic check8(string name, logic [7:0] exp, logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask

   // Pulse length in reference cycles against its window
   task automatic check_len(int cyc);
      n_tests++;
      if (cyc < lo_cyc || cyc > hi_cyc) begin
         fail_count++;
         $display("unexpected pulse length: expected %0d..%0d, seen %0d", lo_cyc, hi_cyc, cyc);
      end
   endtask

   task automatic stop_test;
      $display("checks %0d, mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic reg_write(logic [3:0] a, logic [7:0] d);
      @(posedge ref_clk_in);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk_in);
      reg_wr <= 1'b0;
   endtask

   // Read data is noted now and compared by the watcher one cycle later
   task automatic reg_read(logic [3:0] a, logic [7:0] exp);
      @(posedge ref_clk_in);
      reg_addr <= a;
      reg_rd <= 1'b1;
      rd_q.push_back(exp);
      @(posedge ref_clk_in);
      reg_rd <= 1'b0;
   endtask

   // Window allows for prescaler phase and the two-stage trigger path
   task automatic fire(logic lvl, int div);
      lo_cyc = (ticks - 1) * div + 1;
      hi_cyc = ticks * div + 5;
      @(posedge ref_clk_in);
      want <= lvl;
      t_start = $time;
   endtask

   task automatic wait_pin(logic lvl);
      int k;
      k = 0;
      // The pin keeps its old level for two cycles after fire, so let the pulse start first
      repeat (3) @(posedge ref_clk_in);
      while (pin !== lvl && k < 1000) begin
         @(posedge ref_clk_in);
         k++;
      end
      check8("pulse end", {7'h0, lvl}, {7'h0, pin});
      repeat (3) @(posedge ref_clk_in);
   endtask

   // Watcher: read data the cycle after a read, pin changes against noted levels
   always @(posedge ref_clk_in) begin
      if (rd_seen) begin
         if (rd_q.size() == 0) check8("read queue", 8'h00, 8'hFF);
         else check8("read data", rd_q.pop_front(), reg_rdata_out);
      end
      rd_seen <= reg_rd;
      if (pin !== pin_last) begin
         if (pin_q.size() == 0) check8("pin change", {7'h0, pin_last}, {7'h0, pin});
         else check8("pin level", {7'h0, pin_q.pop_front()}, {7'h0, pin});
         if (pin === after_lvl) check_len(int'(($time - t_start) / 10));
      end
      pin_last <= pin;
   end

   initial begin
      repeat (2) @(posedge ref_clk_in);
      rst_n_in <= 1'b1;
      // Reset values and one unmapped address
      foreach (rst_addr[i]) reg_read(rst_addr[i], rst_val[i]);
      // One pulse at every timer clock choice, random short length
      for (int i = 0; i < 4; i++) begin
         v = 16'(($random(seed) & 7) + 2);
         ticks = int'(v) + 4 + ((i == 0) ? 0 : 1);
         // Mode first: an early match with one-pulse off would set compare flag one
         reg_write(4'h0, 8'h86);
         reg_write(4'h1, {4'hA, sel[i], 2'b00});
         reg_write(4'h6, v[7:0]);
         reg_write(4'h5, 8'h00);
         reg_write(4'h8, 8'h01);
         reg_write(4'h7, 8'h00);
         ext_run <= (i == 3);
         want <= 1'b0;
         repeat (4) @(posedge ref_clk_in);
         pin_q.push_back(1'b1);
         pin_q.push_back(1'b0);
         after_lvl = 1'b0;
         fire(1'b1, dv[i]);
         wait_pin(1'b0);
         check8("oe", 8'h01, {7'h0, pin_oe});
         check8("irq", 8'h01, {7'h0, irq});
         reg_read(4'h3, 8'hFF);
         reg_read(4'h4, 8'hFD);
         reg_read(4'h2, 8'h88);
         reg_read(4'h4, 8'hFD);
         reg_read(4'h8, 8'h01);
         reg_read(4'h2, 8'h00);
         check8("irq", 8'h00, {7'h0, irq});
      end
      ext_run <= 1'b0;
      // Edges ignored with one-pulse off, or with PWM also selected
      for (int i = 0; i < 2; i++) begin
         reg_write(4'h1, (i == 0) ? 8'h80 : 8'hB0);
         want <= 1'b0;
         repeat (4) @(posedge ref_clk_in);
         want <= 1'b1;
         repeat (20) @(posedge ref_clk_in);
         reg_read(4'h2, 8'h00);
      end
      // Falling edge, output undriven, event-layer interrupt
      reg_read(4'hB, 8'h07);
      reg_write(4'hC, 8'h01);
      reg_write(4'h0, 8'h01);
      reg_write(4'h1, 8'h20);
      ticks = int'(v) + 5;
      pin_q.push_back(1'b1);
      after_lvl = 1'b1;
      fire(1'b0, 4);
      repeat (4) @(posedge ref_clk_in);
      check8("oe", 8'h00, {7'h0, pin_oe});
      check8("load", 8'h01, {7'h0, load});
      check8("irq", 8'h01, {7'h0, irq});
      reg_read(4'hB, 8'h01);
      // The clear lands at the read edge, so look one edge later
      @(posedge ref_clk_in);
      check8("irq", 8'h00, {7'h0, irq});
      wait_pin(1'b1);
      reg_read(4'h2, 8'h88);
      stop_test();
   end

   // Hang guard at 20000 cycles, far beyond the few hundred cycles the sequence needs
   initial begin
      #200000;
      fail_count++;
      stop_test();
   end
endmodule
